// ---- hdl/addr_decode_pkg.sv ----
package addr_decode_pkg;

    // Address width of the physical space
    localparam int unsigned ADDR_W = 40;

    // Region bases and last addresses (byte addresses)
    localparam logic [39:0] DDR_BASE = 40'h00_8000_0000;
    localparam logic [39:0] PERIPH_LO_BASE = 40'h00_2000_0000;
    localparam logic [39:0] COHER_BASE = 40'h00_3000_0000;
    localparam logic [39:0] XAXI_BASE = 40'h00_4000_0000;
    localparam logic [39:0] XAXI_LAST = 40'h00_7FBF_FFFF;
    localparam logic [39:0] PERIPH_HI_BASE = 40'h00_7FC0_0000;
    localparam logic [39:0] LOW512_LAST = 40'h00_1FFF_FFFF;
    localparam logic [39:0] DDR_ALIAS_A = 40'h08_0000_0000;
    localparam logic [39:0] DDR_ALIAS_B = 40'h80_0000_0000;

    // 64MB static window index is address bits [28:26]
    localparam int unsigned WIN_LSB = 26;
    localparam int unsigned DDR_OFF_W = 31;

    // Chip-select swap field position in the config word
    localparam int unsigned SWAP_HI = 31;
    localparam int unsigned SWAP_LO = 30;

    // Value of the remap controls after reset
    localparam logic REMAP_AXI_RST = 1'b0;
    localparam logic [1:0] SWAP_RST = 2'h0;

    // Decoded target of a request
    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_STATIC,
        TGT_PERIPH,
        TGT_COHER,
        TGT_XAXI,
        TGT_DDR
    } target_e;

    // Static memory selects, one-hot
    typedef struct packed {
        logic spare_select;
        logic system_register_select;
        logic video_net_usb_select;
        logic pseudostatic_ram_select;
        logic secondary_flash_select;
        logic primary_flash_select;
    } select_s;

    // Request as taken from the requester
    typedef struct packed {
        logic valid;
        logic [39:0] addr;
    } request_s;

    // Routed answer
    typedef struct packed {
        logic valid;
        target_e target;
        select_s selects;
        logic [39:0] addr;
    } route_s;

endpackage : addr_decode_pkg

// ---- hdl/system_address_decoder_remap.sv ----
// Contract
// - Resolve each 40-bit address to one target
// - 2GB at 0x00_8000_0000 goes to DDR2
// - Static mapping puts static controller at zero
// - Two windows route to on-chip peripherals
// - 256MB at 0x00_3000_0000 goes to coherency port
// - 0x00_4000_0000 to 0x00_7FBF_FFFF goes external AXI
// - Primary flash at windows 0,2; window 1 reserved
// - Windows 3..7 assert the remaining selects
// - Two DDR aliases ignore upper address bits
// - Control chooses static or AXI for low 512MB
// - Config bits 31:30 swap flash select at zero
// - Swap only acts under static mapping
// - First fetch at zero follows current remap
// - Remap loadable by preload once out of reset and rewritable at run time
// - Remap controls clear to zero on reset
// - Read-only writes ignored, unused reads zero
`timescale 1ns/1ps

module system_address_decoder_remap
    import addr_decode_pkg::*;
(
    input wire logic clock_i, // Interconnect clock, 250 MHz
    input wire logic arst_n_i, // Asynchronous reset, active low
    input wire addr_decode_pkg::request_s req_i, // Request from requester
    input wire logic cfg_we_i, // Write strobe for remap config word
    input wire logic [31:0] cfg_wdata_i, // Config word, bit 0 remap, 31:30 swap
    input wire logic preload_i, // Boot-time load of the remap settings
    input wire logic [31:0] preload_data_i, // Boot-time config word
    output addr_decode_pkg::route_s route_o, // Registered routing result
    output logic [31:0] cfg_rdata_o, // Current config word readback
    output logic remap_axi_o, // Low 512MB currently on external AXI
    output logic unmapped_o // Last request hit a reserved span
);
    import addr_decode_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Remap configuration

    logic remap_axi_q;
    logic [1:0] swap_q;

    // Remap selection, from boot load or run-time write
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            remap_axi_q <= REMAP_AXI_RST;
        end
        else if (cfg_we_i)
        begin
            remap_axi_q <= cfg_wdata_i[0];
        end
        else if (preload_i)
        begin
            remap_axi_q <= preload_data_i[0];
        end
    end

    // Chip-select swap field
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            swap_q <= SWAP_RST;
        end
        else if (cfg_we_i)
        begin
            swap_q <= cfg_wdata_i[SWAP_HI:SWAP_LO];
        end
        else if (preload_i)
        begin
            swap_q <= preload_data_i[SWAP_HI:SWAP_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode, using settings held before this cycle

    route_s route_d;
    logic unmapped_d;
    logic [2:0] win;
    logic swap_on;

    // Only a nonzero swap field selects the secondary flash at zero
    assign swap_on = (swap_q != 2'h0);
    assign win = req_i.addr[WIN_LSB+2:WIN_LSB];

    // Region match; settings sampled from the registers, so a write in this
    // cycle affects only requests taken afterwards
    always_comb
    begin
        route_d = '0;
        unmapped_d = 1'b0;
        route_d.valid = req_i.valid;
        route_d.addr = req_i.addr;
        route_d.target = TGT_NONE;
        if (req_i.addr <= LOW512_LAST)
        begin
            if (remap_axi_q)
            begin
                route_d.target = TGT_XAXI;
            end
            else
            begin
                route_d.target = TGT_STATIC;
                case (win)
                    3'h0:
                    begin
                        // Swap acts only under static mapping
                        if (swap_on)
                            route_d.selects.secondary_flash_select = 1'b1;
                        else
                            route_d.selects.primary_flash_select = 1'b1;
                    end
                    3'h2: route_d.selects.primary_flash_select = 1'b1;
                    3'h3: route_d.selects.secondary_flash_select = 1'b1;
                    3'h4: route_d.selects.spare_select = 1'b1;
                    3'h5: route_d.selects.pseudostatic_ram_select = 1'b1;
                    3'h6: route_d.selects.video_net_usb_select = 1'b1;
                    3'h7: route_d.selects.system_register_select = 1'b1;
                    default:
                    begin
                        route_d.target = TGT_NONE;
                        unmapped_d = req_i.valid;
                    end
                endcase
            end
        end
        else if (req_i.addr < COHER_BASE)
        begin
            route_d.target = TGT_PERIPH;
        end
        else if (req_i.addr < XAXI_BASE)
        begin
            route_d.target = TGT_COHER;
        end
        else if (req_i.addr <= XAXI_LAST)
        begin
            route_d.target = TGT_XAXI;
        end
        else if (req_i.addr < DDR_BASE)
        begin
            route_d.target = TGT_PERIPH;
        end
        else if (req_i.addr[39:32] == 8'h00 || req_i.addr[39:32] == 8'h08
                 || req_i.addr[39:32] == 8'h80)
        begin
            // DDR block and its aliases: offset keeps the low 31 bits only
            route_d.target = TGT_DDR;
            route_d.addr = {9'h000, req_i.addr[DDR_OFF_W-1:0]};
        end
        else
        begin
            unmapped_d = req_i.valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs

    // Routing result, one cycle after the request
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            route_o <= '0;
            unmapped_o <= 1'b0;
        end
        else
        begin
            route_o <= route_d;
            unmapped_o <= unmapped_d;
        end
    end

    // Config readback, loaded with the settings so it never lags the decode
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cfg_rdata_o <= 32'h0000_0000;
            remap_axi_o <= REMAP_AXI_RST;
        end
        else if (cfg_we_i)
        begin
            // Undefined bits read zero
            cfg_rdata_o <= {cfg_wdata_i[SWAP_HI:SWAP_LO], 29'h0000_0000, cfg_wdata_i[0]};
            remap_axi_o <= cfg_wdata_i[0];
        end
        else if (preload_i)
        begin
            cfg_rdata_o <= {preload_data_i[SWAP_HI:SWAP_LO], 29'h0000_0000,
                            preload_data_i[0]};
            remap_axi_o <= preload_data_i[0];
        end
    end

endmodule : system_address_decoder_remap

// ---- test/addr_checker_assertions.sv ----
`timescale 1ns/1ps

module addr_checker
    import addr_decode_pkg::*;
(
    input wire logic clock_i, // Clock
    input wire logic arst_n_i, // Reset, active low
    input wire addr_decode_pkg::request_s req_i, // Request
    input wire logic cfg_we_i, // Config write
    input wire logic [31:0] cfg_wdata_i, // Config data
    input wire addr_decode_pkg::route_s route_o, // Route
    input wire logic [31:0] cfg_rdata_o, // Config readback
    input wire logic remap_axi_o, // Remap state
    input wire logic unmapped_o // Reserved hit
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);
    logic v;
    logic [39:0] a;
    // Short names for the request fields
    assign v = req_i.valid;
    assign a = req_i.addr;
    ////////////////////////////////////////////////////////////////
    idle_route_a: assert property (!v |=> !route_o.valid)
        else $error("idle request routed");
    ddr_route_a: assert property (v && a[39:31] == 9'h001 |=> route_o.target == TGT_DDR
        && route_o.addr == {9'h000, $past(a[30:0])}) else $error("memory route wrong");
    periph_route_a: assert property (v && (a[39:28] == 12'h002 || a[39:22] == 18'h001FF)
        |=> route_o.target == TGT_PERIPH) else $error("peripheral route wrong");
    coher_route_a: assert property (v && a[39:28] == 12'h003 |=> route_o.target == TGT_COHER)
        else $error("coherency route wrong");
    xaxi_route_a: assert property (v && a >= XAXI_BASE && a <= XAXI_LAST
        |=> route_o.target == TGT_XAXI) else $error("external route wrong");
    low_axi_a: assert property (v && a[39:29] == 11'h000 && remap_axi_o
        |=> route_o.target == TGT_XAXI && route_o.selects == 6'h00) else $error("remap ignored");
    flash_swap_a: assert property (v && a[39:26] == 14'h0000 && !remap_axi_o
        |=> route_o.selects.secondary_flash_select == ($past(cfg_rdata_o[31:30]) != 2'h0))
        else $error("flash swap wrong");
    window_gap_a: assert property (v && a[39:26] == 14'h0001
        |=> unmapped_o && route_o.target == TGT_NONE) else $error("gap window routed");
    cfg_write_a: assert property (cfg_we_i |=> remap_axi_o == $past(cfg_wdata_i[0]))
        else $error("config write lost");
endmodule : addr_checker

// ---- test/requester_model.sv ----
`timescale 1ns/1ps

module requester_model
    import addr_decode_pkg::*;
(
    input wire logic clock_i, // Clock
    output addr_decode_pkg::request_s req_o // Request to decoder
);
    // Idle at start; a released request shows the inverted address
    initial req_o = '0;
    task automatic issue(input logic [39:0] addr);
        @(posedge clock_i);
        req_o <= '{1'b1, addr};
        @(posedge clock_i);
        req_o <= '{1'b0, ~addr};
    endtask : issue
endmodule : requester_model

// ---- test/tb_system_address_decoder_remap.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
    $display("wrong value %s exp %0h got %0h", n, e, s); end end

module tb_system_address_decoder_remap;
    import addr_decode_pkg::*;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    request_s req_i;
    logic cfg_we_i = 1'b0;
    logic [31:0] cfg_wdata_i = 32'h0;
    logic preload_i = 1'b0;
    logic [31:0] preload_data_i = 32'h0;
    route_s route_o;
    logic [31:0] cfg_rdata_o;
    logic remap_axi_o;
    logic unmapped_o;
    int num_errors = 0;
    int checked = 0;
    requester_model requester_model_i (.clock_i(clock_i), .req_o(req_i));
    system_address_decoder_remap system_address_decoder_remap_i (.clock_i(clock_i),
        .arst_n_i(arst_n_i), .req_i(req_i), .cfg_we_i(cfg_we_i), .cfg_wdata_i(cfg_wdata_i),
        .preload_i(preload_i), .preload_data_i(preload_data_i), .route_o(route_o),
        .cfg_rdata_o(cfg_rdata_o), .remap_axi_o(remap_axi_o), .unmapped_o(unmapped_o));
    // Clock, 4 ns period
    initial forever #2 clock_i = ~clock_i;
    ////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task automatic route(input logic [39:0] a, input target_e t, input logic [5:0] s);
        requester_model_i.issue(a);
        #1;
        `CHK("valid", 1'b1, route_o.valid)
        `CHK("target", t, route_o.target)
        `CHK("selects", s, route_o.selects)
        `CHK("unmapped", t == TGT_NONE, unmapped_o)
        if (t != TGT_NONE) `CHK("addr", (t == TGT_DDR) ? {9'h000, a[30:0]} : a, route_o.addr)
    endtask : route
    task automatic set_cfg(input logic pre, input logic [31:0] d);
        @(posedge clock_i);
        cfg_we_i <= !pre;
        cfg_wdata_i <= d;
        preload_i <= pre;
        preload_data_i <= d;
        @(posedge clock_i);
        cfg_we_i <= 1'b0;
        preload_i <= 1'b0;
        #1;
        `CHK("remap", d[0], remap_axi_o)
        `CHK("cfg", {d[31:30], 29'h0, d[0]}, cfg_rdata_o)
    endtask : set_cfg
    task automatic boot_check();
        #1;
        `CHK("remap rst", 1'b0, remap_axi_o)
        `CHK("cfg rst", 32'h0, cfg_rdata_o)
        route(40'h0, TGT_STATIC, 6'h01);
    endtask : boot_check
    task automatic map_check();
        logic [5:0] sel [8] = '{6'h01, 6'h00, 6'h01, 6'h02, 6'h20, 6'h04, 6'h08, 6'h10};
        for (int w = 0; w < 8; w++) route(40'(w) << 26, (w == 1) ? TGT_NONE : TGT_STATIC, sel[w]);
        route(40'h00_2FFF_FFFC, TGT_PERIPH, 6'h00);
        route(40'h00_7FC0_0000, TGT_PERIPH, 6'h00);
        route(40'h00_3000_0000, TGT_COHER, 6'h00);
        route(40'h00_4000_0000, TGT_XAXI, 6'h00);
        route(40'h00_7FBF_FFFF, TGT_XAXI, 6'h00);
        route(40'h00_FFFF_FFFF, TGT_DDR, 6'h00);
        route(40'h08_0000_0010, TGT_DDR, 6'h00);
        route(40'h80_8000_0020, TGT_DDR, 6'h00);
        route(40'h01_0000_0000, TGT_NONE, 6'h00);
    endtask : map_check
    task automatic remap_check();
        fork
            set_cfg(1'b0, 32'h0000_0001);
            route(40'h0, TGT_STATIC, 6'h01);
        join
        route(40'h00_1FFF_FFF0, TGT_XAXI, 6'h00);
        set_cfg(1'b0, 32'hC000_0001);
        route(40'h0, TGT_XAXI, 6'h00);
        set_cfg(1'b0, 32'h4000_0000);
        route(40'h0, TGT_STATIC, 6'h02);
        set_cfg(1'b1, 32'h0000_0001);
        route(40'h0, TGT_XAXI, 6'h00);
    endtask : remap_check
    // Main sequence, with a second reset after remapping
    initial
    begin
        repeat (12) @(posedge clock_i);
        arst_n_i <= 1'b1;
        boot_check();
        map_check();
        remap_check();
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        arst_n_i <= 1'b1;
        boot_check();
        end_sim();
    end
endmodule : tb_system_address_decoder_remap

bind system_address_decoder_remap addr_checker addr_checker_i (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .req_i(req_i), .cfg_we_i(cfg_we_i), .cfg_wdata_i(cfg_wdata_i),
    .route_o(route_o), .cfg_rdata_o(cfg_rdata_o), .remap_axi_o(remap_axi_o),
    .unmapped_o(unmapped_o));
